// *** hdl/vic_consts.vh ***
// Constants for the vectored normal/fast interrupt controller
// Operation
// [R1] Vector read selects highest pending enabled source
// [R2] Vector read drops the normal request line
// [R3] Vector read clears edge-type current source only
// [R4] Vector read pushes current level and number
// [R5] Vector read returns selected source handler address
// [R6] End-of-service write pops the nesting stack
// [R7] After pop, reassert for pending above restored level
// [R8] During service, only higher priority reasserts request
// [R9] Only source 0 raises the fast request
// [R10] Fast path unprioritised; priority field still reads back
// [R11] Source 0 trigger type selects edge/level detection
// [R12] Enable/disable commands bit 0 gate fast source
// [R13] Mask bit 0 shows fast source enabled
// [R14] Fast vector read returns source 0 handler
// [R15] Fast vector register sits at 0xFFFFF104
// [R16] Fast vector read clears edge-type source 0 only
// [R17] Handler removes level source 0 at origin
// [R18] Handler clears level normal source at peripheral
// [R19] Processor writes end-of-service before returning
// [R20] Processor reads vector register from exception address
// [R21] Normal sources carry 3-bit priority, 7 highest
// [R22] Priority ties go to lowest source number
// [R23] Nesting stack holds eight entries
// [R24] No pending source returns the spurious vector
// [R25] Both request lines active low, registered, high after reset
`ifndef VIC_CONSTS_VH
`define VIC_CONSTS_VH

// ==========================================================
// Address map
`define VIC_BASE_HI 20'hFFFFF
`define VIC_SMR_HI 5'h00
`define VIC_SVR_HI 5'h01
`define VIC_OFF_IVR 12'h100
`define VIC_OFF_FVR 12'h104
`define VIC_OFF_ISR 12'h108
`define VIC_OFF_IPR 12'h10C
`define VIC_OFF_IMR 12'h110
`define VIC_OFF_CISR 12'h114
`define VIC_OFF_IECR 12'h120
`define VIC_OFF_IDCR 12'h124
`define VIC_OFF_ICCR 12'h128
`define VIC_OFF_ISCR 12'h12C
`define VIC_OFF_EOI 12'h130
`define VIC_OFF_SPU 12'h134

// ==========================================================
// Mode register fields
`define VIC_PRIO_LSB 0
`define VIC_TYPE_LSB 5
`define VIC_TYPE_LOW 2'h0
`define VIC_TYPE_HIGH 2'h2

// ==========================================================
// Reset values and sizes
`define VIC_RST_WORD 32'h00000000
`define VIC_STACK_DEPTH 4'h8

`endif

// *** hdl/vic_controller.v ***
// Vectored normal/fast interrupt controller with Wishbone slave
`default_nettype none
`include "vic_consts.vh"
module vic_controller (
	input wire clock,
	input wire reset,
	input wire wbCyc,
	input wire wbStb,
	input wire wbWe,
	input wire [31:0] wbAdr,
	input wire [3:0] wbSel,
	input wire [31:0] wbDatWr,
	output wire [31:0] wbDatRd,
	output wire wbAck,
	input wire [31:0] irqSrc,
	output wire normalIrqN,
	output wire fastIrqN
);
	// ==========================================================
	// Bus sequencer states
	localparam ST_IDLE = 2'h0;
	localparam ST_WAIT = 2'h1;
	localparam ST_ACK = 2'h2;

	// ==========================================================
	// Declarations
	reg [1:0] state_r;
	// Answer flops
	reg ack_r;
	reg [31:0] datRd_r;
	// Read source chosen at take
	reg useMem_r;
	reg useSpur_r;
	// Source synchroniser and edge history
	reg [31:0] sync1_r;
	reg [31:0] sync2_r;
	reg [31:0] prev_r;
	// Latched edges
	reg [31:0] edgeFlag_r;
	reg [31:0] edgeFlag_nxt;
	// Enabled sources
	reg [31:0] enable_r;
	// Per-source mode fields
	reg [2:0] prio_r [0:31];
	reg [1:0] type_r [0:31];
	// Spurious vector
	reg [31:0] spurVec_r;
	// Current interrupt context
	reg curValid_r;
	reg [2:0] curLevel_r;
	reg [4:0] curNum_r;
	// Nesting stack and fill count
	reg [8:0] stack_r [0:7];
	reg [3:0] depth_r;
	// Request lines, true = inactive
	reg normalIrqN_r;
	reg fastIrqN_r;
	// Combinational helpers
	reg [31:0] pending;
	reg [31:0] edgeSeen;
	reg [31:0] edgeMask;
	reg [95:0] prioFlat;
	reg [31:0] regRead;
	reg [4:0] memAddr;
	wire found;
	wire [4:0] selNum;
	wire [2:0] selLevel;
	wire [31:0] memData;
	// Loop indices, one per process so that no index has two drivers
	integer i;
	integer j;
	integer k;

	// ==========================================================
	// Decode
	wire take = wbCyc && wbStb && (state_r == ST_IDLE);
	wire inBlk = (wbAdr[31:12] == `VIC_BASE_HI);
	wire [11:0] off = wbAdr[11:0];
	wire rdAcc = take && !wbWe && inBlk;
	wire wrAcc = take && wbWe && inBlk;
	wire isSmr = (off[11:7] == `VIC_SMR_HI);
	wire isSvr = (off[11:7] == `VIC_SVR_HI);
	wire rdIvr = rdAcc && (off == `VIC_OFF_IVR);
	// Fixed absolute address, see [R15]
	wire rdFvr = rdAcc && (off == `VIC_OFF_FVR);
	wire wrIecr = wrAcc && (off == `VIC_OFF_IECR);
	wire wrIdcr = wrAcc && (off == `VIC_OFF_IDCR);
	wire wrIccr = wrAcc && (off == `VIC_OFF_ICCR);
	wire wrIscr = wrAcc && (off == `VIC_OFF_ISCR);
	wire wrEoi = wrAcc && (off == `VIC_OFF_EOI);
	wire wrSpu = wrAcc && (off == `VIC_OFF_SPU);
	wire wrSmr = wrAcc && isSmr;
	wire [3:0] memWe = (wrAcc && isSvr) ? wbSel : 4'h0;

	// ==========================================================
	// Trigger type decode: bit 0 set means edge
	function isEdge;
		input [1:0] t;
		begin
			isEdge = t[0];
		end
	endfunction

	// ==========================================================
	// Pending vector, edge detect and priority packing
	always @* begin
		pending = 32'h00000000;
		edgeSeen = 32'h00000000;
		edgeMask = 32'h00000000;
		prioFlat = 96'h0;
		for (i = 0; i < 32; i = i + 1) begin
			prioFlat[3*i +: 3] = prio_r[i];
			edgeMask[i] = isEdge(type_r[i]);
			// Polarity from bit 1, see [R11]
			if (type_r[i][1]) begin
				edgeSeen[i] = sync2_r[i] && !prev_r[i];
			end else begin
				edgeSeen[i] = !sync2_r[i] && prev_r[i];
			end
			if (isEdge(type_r[i])) begin
				pending[i] = edgeFlag_r[i];
			end else begin
				pending[i] = type_r[i][1] ? sync2_r[i] : !sync2_r[i];
			end
		end
	end

	// ==========================================================
	// Normal selector; source 0 is kept out of it, see [R9]
	vic_prio_sel uSel (
		.reqVec(pending & enable_r & 32'hFFFFFFFE),
		.prioFlat(prioFlat),
		.limitOn(curValid_r),
		.limit(curLevel_r),
		.found(found),
		.selNum(selNum),
		.selLevel(selLevel)
	);

	// ==========================================================
	// Vector memory address: selected source, zero or indexed word
	always @* begin
		if (rdIvr) begin
			memAddr = selNum; // see [R5]
		end else if (rdFvr) begin
			memAddr = 5'h00; // see [R14]
		end else begin
			memAddr = off[6:2];
		end
	end

	vic_vector_mem uMem (
		.clock(clock),
		.reset(reset),
		.wrEn(memWe),
		.addr(memAddr),
		.wrData(wbDatWr),
		.rdData(memData)
	);

	// ==========================================================
	// Edge latch: set wins over any clear
	always @* begin
		edgeFlag_nxt = edgeFlag_r;
		if (wrIccr) begin
			edgeFlag_nxt = edgeFlag_nxt & ~wbDatWr;
		end
		if (rdIvr && found) begin
			edgeFlag_nxt[selNum] = 1'b0; // see [R3]
		end
		if (rdFvr) begin
			edgeFlag_nxt[0] = 1'b0; // see [R16]
		end
		edgeFlag_nxt = edgeFlag_nxt | edgeSeen;
		if (wrIscr) begin
			edgeFlag_nxt = edgeFlag_nxt | wbDatWr;
		end
		// Level sources keep no latch, so the clears leave them alone
		edgeFlag_nxt = edgeFlag_nxt & edgeMask;
	end

	// ==========================================================
	// Register read mux for plain registers
	always @* begin
		regRead = `VIC_RST_WORD;
		if (inBlk) begin
			if (isSmr) begin
				regRead[`VIC_PRIO_LSB +: 3] = prio_r[off[6:2]]; // see [R10]
				regRead[`VIC_TYPE_LSB +: 2] = type_r[off[6:2]];
			end else begin
				case (off)
					`VIC_OFF_ISR: regRead[4:0] = curNum_r;
					`VIC_OFF_IPR: regRead = pending;
					`VIC_OFF_IMR: regRead = enable_r; // see [R13]
					`VIC_OFF_CISR: regRead[1:0] = {!fastIrqN_r, !normalIrqN_r};
					`VIC_OFF_SPU: regRead = spurVec_r;
					default: regRead = `VIC_RST_WORD;
				endcase
			end
		end
	end

	// ==========================================================
	// Source synchroniser; first stage feeds only the second
	always @(posedge clock) begin
		if (reset) begin
			sync1_r <= `VIC_RST_WORD;
			sync2_r <= `VIC_RST_WORD;
			prev_r <= `VIC_RST_WORD;
		end else begin
			sync1_r <= irqSrc;
			sync2_r <= sync1_r;
			prev_r <= sync2_r;
		end
	end

	// ==========================================================
	// Configuration, enables and edge latches
	always @(posedge clock) begin
		if (reset) begin
			edgeFlag_r <= `VIC_RST_WORD;
			enable_r <= `VIC_RST_WORD;
			spurVec_r <= `VIC_RST_WORD;
			for (j = 0; j < 32; j = j + 1) begin
				prio_r[j] <= 3'h0;
				type_r[j] <= `VIC_TYPE_LOW;
			end
		end else begin
			edgeFlag_r <= edgeFlag_nxt;
			// Enable then disable; bit 0 is the fast source, see [R12]
			if (wrIecr || wrIdcr) begin
				enable_r <= (enable_r | (wrIecr ? wbDatWr : 32'h0))
					& ~(wrIdcr ? wbDatWr : 32'h0);
			end
			if (wrSmr && wbSel[0]) begin
				prio_r[off[6:2]] <= wbDatWr[`VIC_PRIO_LSB +: 3];
				type_r[off[6:2]] <= wbDatWr[`VIC_TYPE_LSB +: 2];
			end
			if (wrSpu) begin
				for (j = 0; j < 4; j = j + 1) begin
					if (wbSel[j]) begin
						spurVec_r[8*j +: 8] <= wbDatWr[8*j +: 8];
					end
				end
			end
		end
	end

	// ==========================================================
	// Current context and nesting stack
	always @(posedge clock) begin
		if (reset) begin
			curValid_r <= 1'b0;
			curLevel_r <= 3'h0;
			curNum_r <= 5'h00;
			depth_r <= 4'h0;
			for (k = 0; k < 8; k = k + 1) begin
				stack_r[k] <= 9'h000;
			end
		end else if (rdIvr) begin
			// Save the outgoing context, see [R4]
			if (depth_r < `VIC_STACK_DEPTH) begin // see [R23]
				stack_r[depth_r[2:0]] <= {curValid_r, curLevel_r, curNum_r};
				depth_r <= depth_r + 4'h1;
			end
			// Spurious read leaves the context as it was, see [R24]
			if (found) begin
				curValid_r <= 1'b1; // see [R1]
				curLevel_r <= selLevel;
				curNum_r <= selNum;
			end
		end else if (wrEoi) begin
			// Restore the saved context, see [R6]
			if (depth_r != 4'h0) begin
				{curValid_r, curLevel_r, curNum_r} <= stack_r[depth_r[2:0] - 3'h1];
				depth_r <= depth_r - 4'h1;
			end else begin
				curValid_r <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Request lines, active low from flops, see [R25]
	always @(posedge clock) begin
		if (reset) begin
			normalIrqN_r <= 1'b1;
			fastIrqN_r <= 1'b1;
		end else begin
			// While servicing, only sources above the current level count, see [R2] [R7] [R8]
			normalIrqN_r <= !found;
			// No priority on the fast path, see [R9] [R10]
			fastIrqN_r <= !(pending[0] && enable_r[0]);
		end
	end

	// ==========================================================
	// Bus sequencer: take, wait one cycle for memory, answer
	always @(posedge clock) begin
		if (reset) begin
			state_r <= ST_IDLE;
			ack_r <= 1'b0;
			datRd_r <= `VIC_RST_WORD;
			useMem_r <= 1'b0;
			useSpur_r <= 1'b0;
		end else begin
			case (state_r)
				ST_IDLE: begin
					ack_r <= 1'b0;
					if (take) begin
						state_r <= ST_WAIT;
						useMem_r <= rdFvr || (rdIvr && found) || (rdAcc && isSvr);
						useSpur_r <= rdIvr && !found; // see [R24]
					end
				end
				ST_WAIT: begin
					// Reads of write-only or unmapped words give zero
					if (wbWe) begin
						datRd_r <= `VIC_RST_WORD;
					end else if (useSpur_r) begin
						datRd_r <= spurVec_r;
					end else if (useMem_r) begin
						datRd_r <= memData; // see [R5] [R14]
					end else begin
						datRd_r <= regRead;
					end
					ack_r <= 1'b1;
					state_r <= ST_ACK;
				end
				ST_ACK: begin
					// Drop the answer after one cycle high
					ack_r <= 1'b0;
					state_r <= ST_IDLE;
				end
				default: begin
					ack_r <= 1'b0;
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Outputs
	assign wbAck = ack_r;
	assign wbDatRd = datRd_r;
	assign normalIrqN = normalIrqN_r;
	assign fastIrqN = fastIrqN_r;
endmodule
`default_nettype wire

// *** hdl/vic_prio_sel.v ***
// Priority selector over normal sources 1 to 31
`default_nettype none
module vic_prio_sel (
	input wire [31:0] reqVec,
	input wire [95:0] prioFlat,
	input wire limitOn,
	input wire [2:0] limit,
	output reg found,
	output reg [4:0] selNum,
	output reg [2:0] selLevel
);
	integer i;
	// Priority of the source under test
	reg [2:0] p;

	// ==========================================================
	// Scan downward so that ties keep the lowest number
	always @* begin
		found = 1'b0;
		selNum = 5'h00;
		selLevel = 3'h0;
		p = 3'h0;
		for (i = 31; i >= 1; i = i - 1) begin
			p = prioFlat[3*i +: 3];
			// Above current level only while servicing, see [R8]
			if (reqVec[i] && (!limitOn || p > limit) && (!found || p >= selLevel)) begin // see [R22]
				found = 1'b1;
				selNum = i[4:0];
				selLevel = p; // see [R21]
			end
		end
	end
endmodule
`default_nettype wire

// *** hdl/vic_vector_mem.v ***
// Handler address memory, 32 words, byte writes, registered read
`default_nettype none
module vic_vector_mem (
	input wire clock,
	input wire reset,
	input wire [3:0] wrEn,
	input wire [4:0] addr,
	input wire [31:0] wrData,
	output wire [31:0] rdData
);
	// Storage array
	reg [31:0] mem [0:31];
	// Registered read word
	reg [31:0] rdData_r;
	integer b;

	// ==========================================================
	// Byte writes and registered read
	always @(posedge clock) begin
		for (b = 0; b < 4; b = b + 1) begin
			if (wrEn[b]) begin
				mem[addr][8*b +: 8] <= wrData[8*b +: 8];
			end
		end
		if (reset) begin
			rdData_r <= `VIC_RST_WORD;
		end else begin
			rdData_r <= mem[addr];
		end
	end

	assign rdData = rdData_r;
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the vectored interrupt controller
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
	$display("Error %0t: got %h exp %h", $time, g, e); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] BASE = 32'hFFFFF000; // Block base address
	logic clock, reset, wbCyc, wbStb, wbWe, wbAck, normalIrqN, fastIrqN, irqTaken, fiqTaken;
	logic [3:0] wbSel;
	logic [31:0] wbAdr, wbDatWr, wbDatRd, irqSrc, ev;
	logic [31:0] hw [0:4]; // Handler words, last is spurious
	logic [31:0] expQ [$]; // Expected read data
	int err_count, tests_run, cycles, seed;
	vic_controller DUT (.clock(clock), .reset(reset), .wbCyc(wbCyc), .wbStb(wbStb),
		.wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatWr(wbDatWr), .wbDatRd(wbDatRd),
		.wbAck(wbAck), .irqSrc(irqSrc), .normalIrqN(normalIrqN), .fastIrqN(fastIrqN));
	vic_core_model core (.clock(clock), .normalIrqN(normalIrqN), .fastIrqN(fastIrqN),
		.irqTaken(irqTaken), .fiqTaken(fiqTaken));
	// ==========
	// Clock, read monitor, hang limit
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (wbAck === 1'b1 && !wbWe && expQ.size() > 0) begin
			ev = expQ.pop_front();
			`CHK(wbDatRd, ev)
		end
		if (cycles > 3000) begin
			err_count++;
			$display("Error %0t: timeout", $time);
			print_verdict();
		end
	end
	task print_verdict();
		if (err_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// One classic bus cycle, held until ack
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clock);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= w;
		wbAdr <= a;
		wbDatWr <= d;
		do @(posedge clock); while (wbAck !== 1'b1);
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
	endtask
	task rd(input logic [31:0] a, input logic [31:0] e);
		expQ.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	// Bounded wait for the core to see a request
	task take(input logic f);
		int i;
		i = 0;
		while ((f ? fiqTaken : irqTaken) !== 1'b1 && i < 20) begin
			@(posedge clock);
			i++;
		end
	endtask
	// ==========
	// Main sequence
	initial begin
		seed = 35;
		{wbCyc, wbStb, wbWe, reset} = 4'h1;
		wbSel = 4'hF;
		wbAdr = 32'h0;
		wbDatWr = 32'h0;
		irqSrc = 32'h0;
		repeat (5) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		`CHK({normalIrqN, fastIrqN}, 2'h3)
		for (int n = 0; n < 5; n++) begin
			hw[n] = $random(seed);
			bus(1'b1, (n < 4) ? BASE + 32'h80 + 4 * n : BASE + 32'h134, hw[n]);
		end
		bus(1'b1, BASE + 32'h4, 32'h63);
		bus(1'b1, BASE + 32'h8, 32'h45);
		bus(1'b1, BASE + 32'hC, 32'h45);
		bus(1'b1, BASE + 32'h120, 32'hE);
		rd(BASE + 32'h100, hw[4]);
		bus(1'b1, BASE + 32'h130, 32'h0);
		// Nested normal service
		irqSrc[1] <= 1'b1;
		take(1'b0);
		rd(BASE + 32'h100, hw[1]);
		`CHK(normalIrqN, 1'b1)
		rd(BASE + 32'h10C, 32'hFFFFFFF1);
		irqSrc[3:2] <= 2'h3;
		take(1'b0);
		`CHK(normalIrqN, 1'b0)
		rd(BASE + 32'h100, hw[2]);
		`CHK(normalIrqN, 1'b1)
		irqSrc[2] <= 1'b0;
		repeat (5) @(posedge clock);
		bus(1'b1, BASE + 32'h130, 32'h0);
		`CHK(normalIrqN, 1'b0)
		rd(BASE + 32'h100, hw[3]);
		rd(BASE + 32'h108, 32'h3);
		irqSrc[3] <= 1'b0;
		repeat (5) @(posedge clock);
		bus(1'b1, BASE + 32'h130, 32'h0);
		bus(1'b1, BASE + 32'h130, 32'h0);
		repeat (6) @(posedge clock);
		`CHK(normalIrqN, 1'b1)
		// Fast source, edge then level
		bus(1'b1, BASE, 32'h67);
		rd(BASE, 32'h67);
		bus(1'b1, BASE + 32'h120, 32'h1);
		rd(BASE + 32'h110, 32'hF);
		irqSrc[0] <= 1'b1;
		take(1'b1);
		`CHK({fastIrqN, normalIrqN}, 2'h1)
		rd(BASE + 32'h104, hw[0]);
		`CHK(fastIrqN, 1'b1)
		bus(1'b1, BASE, 32'h40);
		repeat (6) @(posedge clock);
		`CHK(fastIrqN, 1'b0)
		rd(BASE + 32'h104, hw[0]);
		`CHK(fastIrqN, 1'b0)
		irqSrc[0] <= 1'b0;
		repeat (6) @(posedge clock);
		`CHK(fastIrqN, 1'b1)
		// Falling edge type, then set and clear commands
		bus(1'b1, BASE, 32'h20);
		irqSrc[0] <= 1'b1;
		repeat (6) @(posedge clock);
		`CHK(fastIrqN, 1'b1)
		irqSrc[0] <= 1'b0;
		repeat (6) @(posedge clock);
		`CHK(fastIrqN, 1'b0)
		rd(BASE + 32'h104, hw[0]);
		`CHK(fastIrqN, 1'b1)
		bus(1'b1, BASE + 32'h12C, 32'h1);
		rd(BASE + 32'h114, 32'h2);
		bus(1'b1, BASE + 32'h128, 32'h1);
		`CHK(fastIrqN, 1'b1)
		rd(BASE + 32'h134, hw[4]);
		bus(1'b1, BASE + 32'h124, 32'h1);
		rd(BASE + 32'h110, 32'hE);
		rd(32'h00000100, 32'h0);
		repeat (2) @(posedge clock);
		print_verdict();
	end
endmodule
bind vic_controller vic_ctl_props u_props (.clock(clock), .reset(reset), .wbCyc(wbCyc),
	.wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatWr(wbDatWr),
	.wbDatRd(wbDatRd), .wbAck(wbAck), .irqSrc(irqSrc), .normalIrqN(normalIrqN),
	.fastIrqN(fastIrqN));
`default_nettype wire

// *** tb/vic_core_model.sv ***
// Processor core model taking normal and fast requests
`default_nettype none
module vic_core_model (
	input wire logic clock,
	input wire logic normalIrqN,
	input wire logic fastIrqN,
	output logic irqTaken,
	output logic fiqTaken
);
	timeunit 1ns;
	timeprecision 1ps;
	// Core samples both active-low lines each clock
	always @(posedge clock) begin
		irqTaken <= (normalIrqN === 1'b0);
		fiqTaken <= (fastIrqN === 1'b0);
	end
endmodule
`default_nettype wire

// *** tb/vic_ctl_props.sv ***
// Port checker for the vectored interrupt controller
`default_nettype none
module vic_ctl_props (
	input wire logic clock,
	input wire logic reset,
	input wire logic wbCyc,
	input wire logic wbStb,
	input wire logic wbWe,
	input wire logic [31:0] wbAdr,
	input wire logic [3:0] wbSel,
	input wire logic [31:0] wbDatWr,
	input wire logic [31:0] wbDatRd,
	input wire logic wbAck,
	input wire logic [31:0] irqSrc,
	input wire logic normalIrqN,
	input wire logic fastIrqN
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// Shadow of source 0 type and enable
	logic [1:0] type0_r; // Trigger type of source 0
	logic en0_r; // Source 0 enabled
	always @(posedge clock) begin
		if (reset) begin
			type0_r <= 2'h0;
			en0_r <= 1'b0;
		end else if (wbCyc && wbStb && wbWe && !wbAck) begin
			if (wbAdr == 32'hFFFFF000 && wbSel[0])
				type0_r <= wbDatWr[6:5];
			if (wbAdr == 32'hFFFFF120 && wbDatWr[0])
				en0_r <= 1'b1;
			if (wbAdr == 32'hFFFFF124 && wbDatWr[0])
				en0_r <= 1'b0;
		end
	end
	// ==========
	// Properties
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	sequence s_go;
		wbCyc && wbStb && !$past(wbStb);
	endsequence
	sequence s_rd(a);
		wbCyc && wbStb && !$past(wbStb) && !wbWe && wbAdr == a;
	endsequence
	sequence s_answer;
		!wbAck [*2] ##1 wbAck ##1 !wbAck;
	endsequence
	a_ack_timing: assert property (s_go |-> s_answer)
		else $error("bus answer late or long");
	a_lines_reset: assert property ($past(reset) |-> normalIrqN && fastIrqN)
		else $error("request line active after reset");
	a_ivr_drop: assert property (s_rd(32'hFFFFF100) |-> ##2 normalIrqN)
		else $error("normal line kept after vector read");
	a_fvr_edge: assert property (s_rd(32'hFFFFF104) ##0 type0_r[0] |-> ##2 fastIrqN)
		else $error("edge fast source not cleared");
	a_fast_on: assert property ((irqSrc[0] && en0_r && type0_r == 2'h2) [*5] |-> !fastIrqN)
		else $error("high level source 0 not raised");
	a_fast_off: assert property ((!irqSrc[0] && type0_r == 2'h2) [*5] |-> fastIrqN)
		else $error("fast line held without source");
	a_mask_bit: assert property (s_rd(32'hFFFFF110) |-> ##2 wbDatRd[0] == en0_r)
		else $error("mask bit 0 wrong");
	a_unmapped_zero: assert property (s_go ##0 !wbWe && wbAdr[31:12] != 20'hFFFFF
		|-> ##2 wbDatRd == 32'h0)
		else $error("outside read not zero");
endmodule
`default_nettype wire
